// file: core/plm_pkg.sv
// package of constants and types for the priority level manager
package plm_pkg;
  // word and level sizes
  localparam int unsigned WORD_W   = 18;
  localparam int unsigned LEVELS   = 8;
  localparam int unsigned HW_LVLS  = 4;
  localparam int unsigned ADDR_W   = 15;
  localparam int unsigned TRAP_W   = 6;
  // status and control words number bit 00 as the most significant bit
  localparam int unsigned MSB      = 17;
  localparam int unsigned POS_EN   = 0;   // enable bit position
  localparam int unsigned POS_PEND = 2;   // first pending bit (level 0)
  localparam int unsigned POS_SWRQ = 6;   // first software request bit
  localparam int unsigned POS_ACT  = 10;  // first active / raise bit
  // call_subroutine linkage locations (octal)
  localparam logic [14:0] CAL_STORE_ADDR  = 15'h0010; // location 00020
  localparam logic [14:0] CAL_RESUME_ADDR = 15'h0011; // location 00021
  // base of channel locations; software channels sit at fixed offsets 034-037 (octal) inside the 6-bit hardware trap range
  localparam logic [14:0] CHAN_BASE       = 15'h0020; // location 00040
  localparam logic [5:0]  SW_CHAN_FIRST   = 6'h1c;    // arbitrary slot
  localparam logic [2:0]  CAL_LEVEL       = 3'h4;
  localparam logic [3:0]  NO_LEVEL        = 4'h8;
  // reset values
  localparam logic        ENABLE_RST      = 1'b0;
  localparam logic [7:0]  ACTIVE_RST      = 8'h00;

  // full state of the manager
  typedef struct packed {
    logic                   enable;
    logic [LEVELS-1:0]      active;
    logic [3:0]             swReq;
    logic [HW_LVLS-1:0]     hwMeta;
    logic [HW_LVLS-1:0]     hwReq;
    logic [HW_LVLS*TRAP_W-1:0] trapMeta;
    logic [HW_LVLS*TRAP_W-1:0] trapSync;
    logic [WORD_W-1:0]      acOut;
    logic                   acOutValid;
    logic                   grantValid;
    logic [2:0]             grantLevel;
    logic [ADDR_W-1:0]      grantAddr;
    logic                   callValid;
    logic [ADDR_W-1:0]      callStoreAddr;
    logic [ADDR_W-1:0]      callResumeAddr;
  } plm_state_s;
endpackage : plm_pkg

// file: core/plm_priority_level_manager.sv
// priority level manager: levels, requests, grants and status word
`timescale 1ns/10ps

module plm_priority_level_manager
  import plm_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic                      clkEn,
  input  wire logic [WORD_W-1:0]         acWord,
  input  wire logic                      readStatus,
  input  wire logic                      callSub,
  input  wire logic                      debreak,
  input  wire logic                      debreakRestore,
  input  wire logic                      raiseReq,
  input  wire logic                      breakAllowed,
  input  wire logic [HW_LVLS-1:0]        hwReqPin,
  input  wire logic [HW_LVLS*TRAP_W-1:0] hwTrapPin,
  output logic [WORD_W-1:0]              acOut,
  output logic                           acOutValid,
  output logic                           grantValid,
  output logic [2:0]                     grantLevel,
  output logic [ADDR_W-1:0]              grantAddr,
  output logic                           callValid,
  output logic [ADDR_W-1:0]              callStoreAddr,
  output logic [ADDR_W-1:0]              callResumeAddr,
  output logic                           priorityEnable
);

  plm_state_s        stReg;
  plm_state_s        stNext;
  logic [LEVELS-1:0] pending;
  logic [3:0]        highestLvl;
  logic [3:0]        raiseLvl;
  logic [3:0]        candLvl;
  logic              anyInstr;
  logic              grantFire;

  // pending requests: hardware on levels 0-3, software on 4-7
  assign pending  = {stReg.swReq, stReg.hwReq};
  assign anyInstr = readStatus | callSub | debreak | debreakRestore
                    | raiseReq;

  // highest active level (lowest index), raise target, grant candidate
  always_comb
  begin
    highestLvl = NO_LEVEL;
    raiseLvl   = NO_LEVEL;
    candLvl    = NO_LEVEL;
    for (int i = LEVELS - 1; i >= 0; i--)
    begin
      if (stReg.active[i])
        highestLvl = 4'(i);
      if (acWord[MSB - POS_ACT - i])
        raiseLvl = 4'(i);
      if (pending[i])
        candLvl = 4'(i);
    end
  end

  // a grant waits for the processor and for a quiet instruction cycle
  assign grantFire = stReg.enable && breakAllowed && !anyInstr
                     && (candLvl < highestLvl);

  // next-state logic for the whole manager
  always_comb
  begin
    stNext            = stReg;
    stNext.acOutValid = 1'b0;
    stNext.grantValid = 1'b0;
    stNext.callValid  = 1'b0;
    // two-stage capture of device request and trap lines
    stNext.hwMeta     = hwReqPin;
    stNext.hwReq      = stReg.hwMeta;
    stNext.trapMeta   = hwTrapPin;
    stNext.trapSync   = stReg.trapMeta;

    // status word gated into the accumulator
    if (readStatus)
    begin
      stNext.acOutValid = 1'b1;
      stNext.acOut      = '0;
      stNext.acOut[MSB - POS_EN] = stReg.enable;
      for (int i = 0; i < LEVELS; i++)
      begin
        stNext.acOut[MSB - POS_PEND - i] = pending[i];
        stNext.acOut[MSB - POS_ACT - i]  = stReg.active[i];
      end
    end

    // both debreak forms release the highest active level only
    if ((debreak || debreakRestore) && highestLvl != NO_LEVEL)
      stNext.active[highestLvl[2:0]] = 1'b0;

    // subroutine call: fixed linkage and level 4 activation
    // placed after the release so a set in the same cycle wins
    if (callSub)
    begin
      stNext.callValid      = 1'b1;
      stNext.callStoreAddr  = CAL_STORE_ADDR;
      stNext.callResumeAddr = CAL_RESUME_ADDR;
      if (stReg.enable)
        stNext.active[CAL_LEVEL] = 1'b1;
    end

    // control word: enable, software requests, raise
    if (raiseReq)
    begin
      stNext.enable = acWord[MSB - POS_EN];
      if (acWord[MSB - POS_EN])
      begin
        for (int i = 0; i < 4; i++)
          if (acWord[MSB - POS_SWRQ - i])
            stNext.swReq[i] = 1'b1;
        if (raiseLvl < highestLvl)
          stNext.active[raiseLvl[2:0]] = 1'b1;
      end
    end

    // grant: set the level active and present its channel
    if (grantFire)
    begin
      stNext.grantValid = 1'b1;
      stNext.grantLevel = candLvl[2:0];
      stNext.active[candLvl[2:0]] = 1'b1;
      if (candLvl[2])
      begin
        // software channel is fixed per level; the request is consumed
        stNext.swReq[candLvl[1:0]] = 1'b0;
        stNext.grantAddr = CHAN_BASE
          + {9'h000, SW_CHAN_FIRST + {4'h0, candLvl[1:0]}};
      end
      else
      begin
        // device supplies its own channel, whatever level it used
        stNext.grantAddr = CHAN_BASE + {9'h000,
          stReg.trapSync[candLvl[1:0]*TRAP_W +: TRAP_W]};
      end
    end
  end

  // state register, frozen while the clock enable is low except that the synchronous reset still loads
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      stReg        <= '0;
      stReg.enable <= ENABLE_RST;
      stReg.active <= ACTIVE_RST;
    end
    else if (clkEn)
      stReg <= stNext;
  end

  // outputs straight from the state register
  assign acOut          = stReg.acOut;
  assign acOutValid     = stReg.acOutValid;
  assign grantValid     = stReg.grantValid;
  assign grantLevel     = stReg.grantLevel;
  assign grantAddr      = stReg.grantAddr;
  assign callValid      = stReg.callValid;
  assign callStoreAddr  = stReg.callStoreAddr;
  assign callResumeAddr = stReg.callResumeAddr;
  assign priorityEnable = stReg.enable;

  // call and its effects
  sequence seqCall;
    clkEn && callSub && stReg.enable;
  endsequence
  sequence seqCallDone;
    callValid && callStoreAddr == CAL_STORE_ADDR
      && callResumeAddr == CAL_RESUME_ADDR && stReg.active[4];
  endsequence

  AST_STATUS_READ: assert property (@(posedge clock) disable iff (!reset_n)
    clkEn && readStatus |=> acOutValid && acOut[MSB] == $past(stReg.enable)
      && acOut[MSB - 1] == 1'b0 && acOut[0] == $past(stReg.active[7]))
    else $error("status word not loaded");

  AST_CALL_LINK: assert property (@(posedge clock) disable iff (!reset_n)
    seqCall |=> seqCallDone)
    else $error("call linkage or level 4 wrong");

  AST_DEBREAK_ONE: assert property (@(posedge clock) disable iff (!reset_n)
    clkEn && (debreak || debreakRestore) && !raiseReq && !callSub
      && highestLvl != NO_LEVEL
    |=> $countones(stReg.active) == $countones($past(stReg.active)) - 1)
    else $error("debreak did not clear exactly one level");

  AST_RAISE_NOLOWER: assert property (@(posedge clock) disable iff (!reset_n)
    clkEn && raiseReq && !debreak && !debreakRestore
    |=> highestLvl <= $past(highestLvl))
    else $error("raise lowered the level");

  AST_RAISE_NOCHAN: assert property (@(posedge clock) disable iff (!reset_n)
    clkEn && raiseReq |=> !grantValid)
    else $error("channel taken on raise");

  AST_SWREQ_SET: assert property (@(posedge clock) disable iff (!reset_n)
    clkEn && raiseReq && acWord[MSB] && acWord[MSB - POS_SWRQ]
    |=> stReg.swReq[0])
    else $error("software request lost");

  AST_GRANT_ABOVE: assert property (@(posedge clock) disable iff (!reset_n)
    clkEn && grantFire |=> grantValid && grantLevel == $past(candLvl[2:0])
      && stReg.active[grantLevel] && $past(candLvl) < $past(highestLvl))
    else $error("grant not above active level");

  AST_BLOCK_LOW: assert property (@(posedge clock) disable iff (!reset_n)
    clkEn && candLvl >= highestLvl |=> !grantValid)
    else $error("request at or below active level granted");

endmodule : plm_priority_level_manager

// file: testbench/plm_dev_model.sv
// device model: one device raising breaks on a selectable hardware level
`timescale 1ns/10ps
module plm_dev_model
  import plm_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic                      reqOn,
  input  wire logic [1:0]                reqLvl,
  input  wire logic [TRAP_W-1:0]         trap,
  input  wire logic                      grantValid,
  input  wire logic [2:0]                grantLevel,
  output logic      [HW_LVLS-1:0]        hwReqPin,
  output logic      [HW_LVLS*TRAP_W-1:0] hwTrapPin
);
  logic              upReg;
  logic [TRAP_W-1:0] junkReg;
  // flag set by command, cleared when the manager grants its level
  always_ff @(posedge clock)
  begin
    junkReg <= reset_n ? ~junkReg : 6'h2a;
    if (!reset_n)
      upReg <= 1'b0;
    else if (reqOn)
      upReg <= 1'b1;
    else if (grantValid && grantLevel == {1'b0, reqLvl})
      upReg <= 1'b0;
  end
  // level chosen by program; idle trap lines toggle
  always_comb
  begin
    hwReqPin = '0;
    hwReqPin[reqLvl] = upReg;
    for (int i = 0; i < HW_LVLS; i++)
      hwTrapPin[i*TRAP_W +: TRAP_W] = (upReg && reqLvl == i) ? trap : junkReg;
  end
endmodule : plm_dev_model

// file: testbench/plm_priority_level_manager_test.sv
// self-checking bench for the priority level manager
`timescale 1ns/10ps
module plm_priority_level_manager_test
  import plm_pkg::*;
;
  localparam logic [17:0] EN = 18'h20000;
  logic clock, reset_n, readStatus, callSub, debreak, debreakRestore;
  logic raiseReq, breakAllowed, reqOn, acOutValid, grantValid;
  logic callValid, priorityEnable, clkEn;
  logic [1:0] reqLvl;
  logic [TRAP_W-1:0] trap;
  logic [WORD_W-1:0] acWord, acOut;
  logic [2:0] grantLevel, lastLvl;
  logic [ADDR_W-1:0] grantAddr, lastAddr, callStoreAddr, callResumeAddr;
  logic [HW_LVLS-1:0] hwReqPin;
  logic [HW_LVLS*TRAP_W-1:0] hwTrapPin;
  int failures = 0;
  int n_tests = 0;
  int grants = 0;

  plm_priority_level_manager u_plm_priority_level_manager (.clock,
    .reset_n, .clkEn, .acWord, .readStatus, .callSub, .debreak,
    .debreakRestore, .raiseReq, .breakAllowed, .hwReqPin, .hwTrapPin,
    .acOut, .acOutValid, .grantValid, .grantLevel, .grantAddr, .callValid,
    .callStoreAddr, .callResumeAddr, .priorityEnable);
  plm_dev_model u_plm_dev_model (.clock, .reset_n, .reqOn, .reqLvl, .trap,
    .grantValid, .grantLevel, .hwReqPin, .hwTrapPin);

  // clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // remember each break granted
  always @(negedge clock)
    if (grantValid === 1'b1)
    begin
      grants++;
      lastLvl = grantLevel;
      lastAddr = grantAddr;
    end

  task automatic tally_and_finish();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic hang();
    failures++;
    tally_and_finish();
  endtask : hang
  task automatic check(input string n, input logic [17:0] e,
                       input logic [17:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : check
  // expected status word, level i at bit i of p and a
  function automatic logic [17:0] st(input logic en, input logic [7:0] p,
                                     input logic [7:0] a);
    st = '0;
    st[17] = en;
    for (int i = 0; i < 8; i++)
    begin
      st[15-i] = p[i];
      st[7-i] = a[i];
    end
  endfunction : st
  // one-cycle instruction strobe: 0 read 1 call 2 dbk 3 dbr 4 raise
  task automatic instr(input int op, input logic [17:0] w);
    @(negedge clock);
    acWord = w;
    readStatus = op == 0;
    callSub = op == 1;
    debreak = op == 2;
    debreakRestore = op == 3;
    raiseReq = op == 4;
    @(negedge clock);
    {readStatus, callSub, debreak, debreakRestore, raiseReq} = '0;
  endtask : instr
  task automatic readSt(input logic [17:0] e);
    instr(0, '0);
    if (acOutValid !== 1'b1)
      hang();
    check("status", e, acOut);
  endtask : readSt
  task automatic waitGrant(input logic [2:0] l, input logic [14:0] a);
    int g0;
    g0 = grants;
    for (int i = 0; i < 20 && grants == g0; i++)
      @(negedge clock);
    if (grants == g0)
      hang();
    check("grant level", 18'(l), 18'(lastLvl));
    check("grant addr", 18'(a), 18'(lastAddr));
  endtask : waitGrant
  task automatic quiet();
    int g0;
    g0 = grants;
    repeat (8) @(negedge clock);
    check("grant count", 18'(g0), 18'(grants));
  endtask : quiet
  task automatic dev(input logic [1:0] l);
    reqLvl = l;
    reqOn = 1'b1;
    @(negedge clock);
    reqOn = 1'b0;
  endtask : dev

  // main sequence
  initial
  begin
    {reset_n, readStatus, callSub, debreak, debreakRestore} = '0;
    {raiseReq, breakAllowed, reqOn, reqLvl, acWord} = '0;
    trap = 6'h05;
    clkEn = 1'b1;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    readSt(st(1'b0, 8'h00, 8'h00));
    instr(4, EN | 18'h00500);
    readSt(st(1'b1, 8'ha0, 8'h00));
    breakAllowed = 1'b1;
    waitGrant(3'h5, 15'h003d);
    readSt(st(1'b1, 8'h80, 8'h20));
    instr(2, '0);
    waitGrant(3'h7, 15'h003f);
    instr(1, '0);
    check("call", 18'h1, 18'(callValid));
    check("store", 18'h10, 18'(callStoreAddr));
    check("resume", 18'h11, 18'(callResumeAddr));
    readSt(st(1'b1, 8'h00, 8'h90));
    instr(3, '0);
    readSt(st(1'b1, 8'h00, 8'h80));
    instr(3, '0);
    instr(4, EN | 18'h00020);
    quiet();
    instr(4, EN | 18'h00010);
    readSt(st(1'b1, 8'h00, 8'h04));
    dev(2'h2);
    quiet();
    readSt(st(1'b1, 8'h04, 8'h04));
    instr(2, '0);
    waitGrant(3'h2, 15'h0025);
    instr(1, '0);
    dev(2'h3);
    quiet();
    breakAllowed = 1'b0;
    instr(3, '0);
    readSt(st(1'b1, 8'h08, 8'h10));
    breakAllowed = 1'b1;
    waitGrant(3'h3, 15'h0025);
    quiet();
    readSt(st(1'b1, 8'h00, 8'h18));
    // frozen clock enable: a debreak must leave the levels alone
    clkEn = 1'b0;
    instr(2, '0);
    clkEn = 1'b1;
    readSt(st(1'b1, 8'h00, 8'h18));
    check("enable", 18'h1, 18'(priorityEnable));
    // control word with bit 00 clear disables and requests nothing
    instr(4, 18'h00500);
    readSt(st(1'b0, 8'h00, 8'h18));
    check("enable", 18'h0, 18'(priorityEnable));
    // re-enable, then a mid-run reset clears enable and levels
    instr(4, EN);
    check("enable", 18'h1, 18'(priorityEnable));
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    check("enable", 18'h0, 18'(priorityEnable));
    readSt(st(1'b0, 8'h00, 8'h00));
    tally_and_finish();
  end
endmodule : plm_priority_level_manager_test
